// File: sim/test_tle_top.sv
// Bench for tle_top: APB register tasks, transmit bit driver, cable model.
// Assumes a 20 MHz i_mclk; the transmit clock runs at a quarter of it.
`timescale 1ns/10ps
module test_tle_top;
    import tle_pkg::*;
    localparam int          CABLE_FEET = 100;
    localparam logic [23:0] PAT_P      = 24'h806108;
    localparam logic [23:0] PAT_N      = 24'h593018;
    logic        mclk  = 1'b0;
    logic        rst   = 1'b1;
    logic        psel  = 1'b0;
    logic        pen   = 1'b0;
    logic        pwr   = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwd   = 32'h0;
    logic        host  = 1'b1;
    logic        lvl   = 1'b0;
    logic        e3    = 1'b0;
    logic        txon  = 1'b0;
    logic        tclk  = 1'b0;
    logic        dp    = 1'b0;
    logic        dn    = 1'b0;
    logic        cut   = 1'b0;
    logic        sr    = 1'b0;
    logic [31:0] prd, rd;
    logic        rdy, err, serr, lp, ln, loe, boe, flt, irq, mp, mn;
    logic [1:0]  ex [28];
    logic [1:0]  got;
    int          bad_count   = 0;
    int          comparisons = 0;
    int          cycles      = 0;
    tle_top dut_u (
        .i_mclk(mclk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwd), .i_pstrb(4'hf), .o_prdata(prd), .o_pready(rdy),
        .o_pslverr(serr), .i_host_mode(host), .i_rail_format_sel(sr), .i_buildout_level_sel(lvl),
        .i_rate_e3(e3), .i_transmitter_on(txon), .i_transmit_clock(tclk), .i_tx_data_pos(dp),
        .i_tx_data_neg(dn), .i_monitor_in_pos(mp), .i_monitor_in_neg(mn), .o_line_out_pos(lp),
        .o_line_out_neg(ln), .o_line_out_oe(loe), .o_buildout_en(boe), .o_drive_fault_out(flt),
        .o_irq(irq)
    );
    tle_cable_model cable_u (
        .i_line_pos(lp), .i_line_neg(ln), .i_line_oe(loe), .i_cut(cut), .o_mon_pos(mp), .o_mon_neg(mn)
    );
    // Clock and hang guard
    initial begin
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (bad_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // One APB transfer; waits for pready, the bench timeout ends a hang
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel  <= 1'b1;
        pen   <= 1'b0;
        pwr   <= w;
        paddr <= a;
        pwd   <= d;
        @(posedge mclk);
        pen <= 1'b1;
        do begin
            @(posedge mclk);
        end while (rdy !== 1'b1);
        rd   = prd;
        err  = serr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic do_reset();
        @(posedge mclk);
        rst <= 1'b1;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
    endtask
    // One transmit bit period of four mclk; line taken after the update
    task automatic bitx(input logic p, input logic n);
        @(posedge mclk);
        tclk <= 1'b1;
        dp   <= p;
        dn   <= n;
        repeat (2) @(posedge mclk);
        tclk <= 1'b0;
        @(posedge mclk);
        #1 got = {lp, ln};
    endtask
    task automatic marks(input int cnt, input logic on);
        for (int k = 0; k < cnt; k++) bitx(on & ~k[0], on & k[0]);
    endtask
    // Expected line symbols: mode 0 three-zero, 1 four-zero, 2 dual rail
    task automatic calc(input int m);
        int z, par, n;
        logic lq, p;
        n = (m == 1) ? 4 : 3;
        z = 0;
        par = 0;
        lq = 1'b0;
        for (int k = 0; k < 28; k++) begin
            p = (k < 24) ? PAT_P[23-k] : 1'b0;
            ex[k] = 2'b00;
            if (m == 2) begin
                ex[k] = p ? 2'b10 : ((k < 24 && PAT_N[23-k]) ? 2'b01 : 2'b00);
            end else if (p) begin
                ex[k] = lq ? 2'b01 : 2'b10;
                lq = ~lq;
                par ^= 1;
                z = 0;
            end else if (++z == n) begin
                if (par == 0) begin
                    ex[k-n+1] = lq ? 2'b01 : 2'b10;
                    lq = ~lq;
                end
                ex[k] = lq ? 2'b10 : 2'b01;
                par = 0;
                z = 0;
            end
        end
    endtask
    // Main sequence
    initial begin
        lvl <= (CABLE_FEET > 225);
        do_reset();
        wr(12'h010, 32'hffffffff);
        wr(TLE_OFS_STATUS, 32'hffffffff);
        rdc(TLE_OFS_CTRL, 32'h0);
        rdc(TLE_OFS_STATUS, 32'h4);
        rdc(TLE_OFS_IRQ_STAT, 32'h0);
        rdc(TLE_OFS_IRQ_EN, 32'h0);
        rdc(12'h010, 32'h0);
        chk({31'h0, err}, 32'h1);
        for (int m = 0; m < 3; m++) begin
            int lat;
            lat = (m == 1) ? 4 : ((m == 2) ? 0 : 3);
            do_reset();
            txon <= 1'b1;
            wr(TLE_OFS_CTRL, {28'h1, 1'b1, m == 1, 1'b0, m < 2});
            calc(m);
            for (int k = 0; k < 28; k++) begin
                bitx(k < 24 && PAT_P[23-k], m == 2 && k < 24 && PAT_N[23-k]);
                chk({30'h0, got}, {30'h0, (k >= lat) ? ex[k-lat] : 2'b00});
            end
        end
        for (int i = 0; i < 32; i++) begin
            logic bx, ox;
            bx = ~i[0] & ~i[1];
            ox = i[3] & (i[2] | ~i[4]);
            @(posedge mclk);
            host <= i[4];
            txon <= i[3];
            e3   <= i[1];
            lvl  <= i[0];
            sr   <= i[2];
            wr(TLE_OFS_CTRL, {27'h0, i[2], 1'b0, i[1], i[0], 1'b0});
            repeat (3) @(posedge mclk);
            #1 chk({31'h0, boe}, {31'h0, bx});
            chk({31'h0, loe}, {31'h0, ox});
            rdc(TLE_OFS_STATUS, {27'h0, i[1], ~i[4] & i[2], bx, ox, 1'b0});
        end
        @(posedge mclk);
        host <= 1'b1;
        txon <= 1'b1;
        lvl  <= 1'b0;
        e3   <= 1'b0;
        wr(TLE_OFS_CTRL, 32'h18);
        cut <= 1'b1;
        marks(200, 1'b1);
        chk({31'h0, flt}, 32'h0);
        wr(TLE_OFS_CTRL, 32'h10);
        marks(96, 1'b1);
        chk({31'h0, flt}, 32'h0);
        marks(64, 1'b1);
        chk({31'h0, flt}, 32'h1);
        rdc(TLE_OFS_STATUS, 32'h7);
        chk({31'h0, irq}, 32'h0);
        wr(TLE_OFS_IRQ_EN, 32'h1);
        repeat (2) @(posedge mclk);
        #1 chk({31'h0, irq}, 32'h1);
        cut <= 1'b0;
        marks(4, 1'b1);
        chk({31'h0, flt}, 32'h0);
        rdc(TLE_OFS_STATUS, 32'h6);
        rdc(TLE_OFS_IRQ_STAT, 32'h1);
        rdc(TLE_OFS_IRQ_STAT, 32'h0);
        #1 chk({31'h0, irq}, 32'h0);
        marks(200, 1'b0);
        chk({31'h0, flt}, 32'h1);
        #1 chk({31'h0, irq}, 32'h1);
        wr(TLE_OFS_IRQ_STAT, 32'h1);
        #1 chk({31'h0, irq}, 32'h0);
        end_of_test();
    end
endmodule

// File: sim/tle_cable_model.sv
// Cable toward the cross-connect with a resistive monitor tap.
// Assumes the line is terminated to ground, so a released line reads low.
`timescale 1ns/10ps
module tle_cable_model (
    input  wire logic i_line_pos,
    input  wire logic i_line_neg,
    input  wire logic i_line_oe,
    input  wire logic i_cut,
    output logic      o_mon_pos,
    output logic      o_mon_neg
);
    // Tap follows the driven line; a cut tap or released line reads low
    assign o_mon_pos = i_line_oe & ~i_cut & i_line_pos;
    assign o_mon_neg = i_line_oe & ~i_cut & i_line_neg;
endmodule

// File: sim/tle_top_asserts.sv
// Checker for tle_top: bus errors, line output, enable and drive monitor.
// Assumes it is bound to tle_top and sees only its ports.
`timescale 1ns/10ps
module tle_top_asserts (
    input wire logic        i_mclk,
    input wire logic        i_sys_rst,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic [11:0] i_paddr,
    input wire logic        o_pslverr,
    input wire logic        i_host_mode,
    input wire logic        i_transmitter_on,
    input wire logic        i_transmit_clock,
    input wire logic        i_monitor_in_pos,
    input wire logic        i_monitor_in_neg,
    input wire logic        o_line_out_pos,
    input wire logic        o_line_out_neg,
    input wire logic        o_line_out_oe,
    input wire logic        o_drive_fault_out,
    input wire logic        o_irq
);
    logic       tclk_q;
    logic [7:0] qline_q;
    logic [7:0] qmon_q;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    // Silent strobes on own output and on the monitor pair, saturating
    always_ff @(posedge i_mclk) begin
        tclk_q <= i_transmit_clock;
        if (i_sys_rst) begin
            qline_q <= 8'h00;
            qmon_q  <= 8'h00;
        end else if (i_transmit_clock && !tclk_q) begin
            qline_q <= (o_line_out_pos | o_line_out_neg) ? 8'h00 : qline_q + {7'h0, qline_q != 8'hff};
            qmon_q  <= (i_monitor_in_pos | i_monitor_in_neg) ? 8'h00 : qmon_q + {7'h0, qmon_q != 8'hff};
        end
    end
    err_access_a: assert property (o_pslverr |-> i_psel && i_penable)
        else $error("slave error outside access phase");
    err_unmapped_a: assert property (i_psel && i_penable && i_paddr > 12'h00c |-> o_pslverr)
        else $error("no slave error on unmapped address");
    off_hiz_a: assert property (!o_line_out_oe |-> !o_line_out_pos && !o_line_out_neg)
        else $error("line pulse while transmitter off");
    one_rail_a: assert property (!(o_line_out_pos && o_line_out_neg))
        else $error("both line rails high");
    tx_off_a: assert property (!i_transmitter_on [*3] |=> !o_line_out_oe)
        else $error("driver on with enable pin low");
    tx_pin_on_a: assert property ((!i_host_mode && i_transmitter_on) [*3] |=> o_line_out_oe)
        else $error("driver off with pin high in hardware mode");
    fault_early_a: assert property ($rose(o_drive_fault_out) |-> qline_q > 8'd90 || qmon_q > 8'd90)
        else $error("drive fault raised too early");
    fault_late_a: assert property (qline_q > 8'd170 && qmon_q > 8'd170 |-> o_drive_fault_out)
        else $error("drive fault missing on silent line");
    fault_clear_a: assert property ($fell(o_drive_fault_out) |-> qline_q < 8'd4 || qmon_q < 8'd4)
        else $error("drive fault cleared without marks");
    cover property ($rose(o_drive_fault_out));
    cover property ($rose(o_irq));
    cover property (o_pslverr);
endmodule

bind tle_top tle_top_asserts chk_u (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_paddr(i_paddr), .o_pslverr(o_pslverr), .i_host_mode(i_host_mode),
    .i_transmitter_on(i_transmitter_on), .i_transmit_clock(i_transmit_clock),
    .i_monitor_in_pos(i_monitor_in_pos), .i_monitor_in_neg(i_monitor_in_neg),
    .o_line_out_pos(o_line_out_pos), .o_line_out_neg(o_line_out_neg), .o_line_out_oe(o_line_out_oe),
    .o_drive_fault_out(o_drive_fault_out), .o_irq(o_irq)
);

// File: verilog/tle_drive_mon.sv
// Transmit drive monitor: flags a line that shows no marks.
// Assumes i_strobe pulses once per transmit clock period.
`timescale 1ns/10ps
module tle_drive_mon
    import tle_pkg::*;
(
    input  wire logic      i_mclk,
    input  wire logic      i_sys_rst,
    input  wire logic      i_strobe,
    input  wire tle_rail_t i_line,
    output logic           o_fault,
    output logic           o_fault_set
);

    tle_mon_state_t q;
    tle_mon_state_t d;

    // Count silent periods, clear on any mark
    always_comb begin
        d = q;
        if (i_strobe) begin
            if (i_line.pos | i_line.neg) begin
                d.cnt   = 8'h00;
                d.fault = 1'b0;                            // [R12]
            end else if (q.cnt != TLE_MON_LIMIT) begin
                d.cnt = q.cnt + 8'h01;
                if (d.cnt == TLE_MON_LIMIT) d.fault = 1'b1;    // [R11]
            end
        end
    end

    // State register
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) q <= '0;
        else q <= d;
    end

    assign o_fault     = q.fault;
    assign o_fault_set = d.fault & ~q.fault;

endmodule

// File: verilog/tle_pkg.sv
// Package for the transmit line encoder with drive monitor:
// register map, field positions, reset values, counts and carrier types.
// Assumes a single 20 MHz system clock and an APB register bus.
// Function
// R1: Single rail encodes B3ZS, or HDB3 at E3
// R2: B3ZS replaces three zeros by B0V or 00V
// R3: B3ZS keeps odd marks between violations
// R4: HDB3 replaces four zeros by 000V or B00V
// R5: HDB3 keeps odd marks between violations
// R6: Dual rail bypasses the encoder automatically
// R7: Dual rail violations sent as valid pulses
// R8: Build-out enabled at 0, disabled at 1
// R9: E3 rate always disables build-out
// R10: Host enables build-out below 225 feet
// R11: 128 silent periods raise drive fault and flags
// R12: Transitions clear fault; sticky flag until read
// R13: Enabled sticky drive fault raises interrupt
// R14: Monitor-select one watches own output
// R15: Monitor-select zero watches external monitor inputs
// R16: Enable pin rules; host bit hands over control
// R17: Transmitter off places line outputs high impedance
// R18: Control bit 0 selects single or dual rail
// R19: Zero-run count restarts on marks, per clock
package tle_pkg;

    // Register byte offsets
    localparam logic [11:0] TLE_OFS_CTRL     = 12'h000;
    localparam logic [11:0] TLE_OFS_STATUS   = 12'h004;
    localparam logic [11:0] TLE_OFS_IRQ_STAT = 12'h008;
    localparam logic [11:0] TLE_OFS_IRQ_EN   = 12'h00c;

    // Control register fields
    localparam int TLE_CTRL_SINGLE_RAIL = 0;
    localparam int TLE_CTRL_BUILDOUT    = 1;
    localparam int TLE_CTRL_RATE_E3     = 2;
    localparam int TLE_CTRL_MON_SELF    = 3;
    localparam int TLE_CTRL_TX_ON       = 4;
    localparam logic [4:0] TLE_CTRL_RST = 5'h00;

    // Status register fields
    localparam int TLE_STAT_FAULT       = 0;
    localparam int TLE_STAT_TX_ON       = 1;
    localparam int TLE_STAT_BUILDOUT_EN = 2;
    localparam int TLE_STAT_SINGLE_RAIL = 3;
    localparam int TLE_STAT_RATE_E3     = 4;

    // Interrupt status and enable share this bit
    localparam int TLE_IRQ_FAULT = 0;

    // Zero-run lengths and monitor silence limit in transmit clocks
    localparam logic [2:0] TLE_B3ZS_RUN  = 3'h3;
    localparam logic [2:0] TLE_HDB3_RUN  = 3'h4;
    localparam logic [7:0] TLE_MON_LIMIT = 8'h80;

    // Pulse pair on the two rails
    typedef struct packed {
        logic pos;
        logic neg;
    } tle_rail_t;

    // Symbol waiting in the encoder delay line
    typedef struct packed {
        logic mark;
        logic viol;
    } tle_tag_t;

    typedef struct packed {
        tle_tag_t [3:0] pipe;
        logic [2:0]     zrun;
        logic           parity;
        logic           last_pol;
        tle_rail_t      out;
    } tle_enc_state_t;

    typedef struct packed {
        logic [7:0] cnt;
        logic       fault;
    } tle_mon_state_t;

endpackage

// File: verilog/tle_top.sv
// Transmit line encoder with build-out, enable and drive monitor,
// registers reached over APB.
// Assumes all inputs, the transmit clock among them, are synchronous
// to i_mclk, and the transmit clock runs at no more than a quarter of i_mclk.
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
module tle_top
    import tle_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_sys_rst,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    input  wire logic [3:0]  i_pstrb,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Mode and hardware-mode control pins
    input  wire logic        i_host_mode,
    input  wire logic        i_rail_format_sel,
    input  wire logic        i_buildout_level_sel,
    input  wire logic        i_rate_e3,
    input  wire logic        i_transmitter_on,
    // Terminal side
    input  wire logic        i_transmit_clock,
    input  wire logic        i_tx_data_pos,
    input  wire logic        i_tx_data_neg,
    // External monitor inputs
    input  wire logic        i_monitor_in_pos,
    input  wire logic        i_monitor_in_neg,
    // Line side
    output logic             o_line_out_pos,
    output logic             o_line_out_neg,
    output logic             o_line_out_oe,
    output logic             o_buildout_en,
    output logic             o_drive_fault_out,
    output logic             o_irq
);

    typedef struct packed {
        logic [31:0] prdata;
        logic        single_rail;
        logic        buildout_lvl;
        logic        rate_e3;
        logic        mon_self;
        logic        tx_on_bit;
        logic        irq_status;
        logic        irq_en;
        logic        irq;
        logic        buildout_en;
        logic        tx_on;
        tle_rail_t   line;
        logic        txclk_prev;
    } tle_top_state_t;

    tle_top_state_t q;
    tle_top_state_t d;

    tle_rail_t   tx_in;
    tle_rail_t   enc_line;
    tle_rail_t   mon_line;
    logic        strobe;
    logic        eff_single;
    logic        eff_lvl;
    logic        eff_e3;
    logic        eff_on;
    logic        fault;
    logic        fault_set;
    logic        setup;
    logic        access;
    logic        hit_ctrl;
    logic        hit_stat;
    logic        hit_istat;
    logic        hit_ien;
    logic        mapped;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;

    // Transmit clock rising edge
    assign strobe = i_transmit_clock & ~q.txclk_prev;

    // Host mode takes register bits, transmitter on also needing its pin; hardware mode takes pins
    assign eff_single = i_host_mode ? q.single_rail : i_rail_format_sel;    // [R18]
    assign eff_lvl    = i_host_mode ? q.buildout_lvl : i_buildout_level_sel;
    assign eff_e3     = i_host_mode ? q.rate_e3 : i_rate_e3;
    assign eff_on     = i_host_mode ? (q.tx_on_bit & i_transmitter_on)
                                    : i_transmitter_on;                    // [R16]

    // Data rails from the terminal
    assign tx_in.pos = i_tx_data_pos;
    assign tx_in.neg = i_tx_data_neg;

    // Line coder
    tle_zs_encoder u_enc (
        .i_mclk        (i_mclk),
        .i_sys_rst     (i_sys_rst),
        .i_strobe      (strobe),
        .i_single_rail (eff_single),
        .i_rate_e3     (eff_e3),
        .i_data        (tx_in),
        .o_line        (enc_line)
    );

    // Monitor source: own driven output or external pins
    always_comb begin
        if (q.mon_self) begin
            mon_line.pos = q.line.pos & q.tx_on;           // [R14]
            mon_line.neg = q.line.neg & q.tx_on;
        end else begin
            mon_line.pos = i_monitor_in_pos;               // [R15]
            mon_line.neg = i_monitor_in_neg;
        end
    end

    // Drive monitor
    tle_drive_mon u_mon (
        .i_mclk      (i_mclk),
        .i_sys_rst   (i_sys_rst),
        .i_strobe    (strobe),
        .i_line      (mon_line),
        .o_fault     (fault),
        .o_fault_set (fault_set)
    );

    // APB address decode
    assign setup     = i_psel & ~i_penable;
    assign access    = i_psel & i_penable;
    assign hit_ctrl  = (i_paddr == TLE_OFS_CTRL);
    assign hit_stat  = (i_paddr == TLE_OFS_STATUS);
    assign hit_istat = (i_paddr == TLE_OFS_IRQ_STAT);
    assign hit_ien   = (i_paddr == TLE_OFS_IRQ_EN);
    assign mapped    = hit_ctrl | hit_stat | hit_istat | hit_ien;
    assign wr        = access & i_pwrite & mapped & i_pstrb[0];
    assign rd        = access & ~i_pwrite & mapped;

    // Zero-wait slave, error on unmapped address
    assign o_pready  = 1'b1;
    assign o_pslverr = access & ~mapped;

    // Read data mux, sampled in the setup cycle
    always_comb begin
        rdata = 32'h0000_0000;
        if (hit_ctrl) begin
            rdata[TLE_CTRL_SINGLE_RAIL] = q.single_rail;
            rdata[TLE_CTRL_BUILDOUT]    = q.buildout_lvl;
            rdata[TLE_CTRL_RATE_E3]     = q.rate_e3;
            rdata[TLE_CTRL_MON_SELF]    = q.mon_self;
            rdata[TLE_CTRL_TX_ON]       = q.tx_on_bit;
        end
        if (hit_stat) begin
            rdata[TLE_STAT_FAULT]       = fault;
            rdata[TLE_STAT_TX_ON]       = q.tx_on;
            rdata[TLE_STAT_BUILDOUT_EN] = q.buildout_en;
            rdata[TLE_STAT_SINGLE_RAIL] = eff_single;
            rdata[TLE_STAT_RATE_E3]     = eff_e3;
        end
        if (hit_istat) rdata[TLE_IRQ_FAULT] = q.irq_status;
        if (hit_ien) rdata[TLE_IRQ_FAULT] = q.irq_en;
    end

    // Next state of registers and line outputs
    always_comb begin
        d = q;
        d.txclk_prev = i_transmit_clock;
        if (setup) d.prdata = rdata;
        // Control register
        if (wr && hit_ctrl) begin
            d.single_rail  = i_pwdata[TLE_CTRL_SINGLE_RAIL];    // [R18]
            d.buildout_lvl = i_pwdata[TLE_CTRL_BUILDOUT];
            d.rate_e3      = i_pwdata[TLE_CTRL_RATE_E3];
            d.mon_self     = i_pwdata[TLE_CTRL_MON_SELF];
            d.tx_on_bit    = i_pwdata[TLE_CTRL_TX_ON];
        end
        if (wr && hit_ien) d.irq_en = i_pwdata[TLE_IRQ_FAULT];
        // Sticky flag: cleared by read or write-one, set wins
        if ((rd && hit_istat) || (wr && hit_istat && i_pwdata[TLE_IRQ_FAULT]))
            d.irq_status = 1'b0;                           // [R12]
        if (fault_set) d.irq_status = 1'b1;                // [R11]
        d.irq = d.irq_status & d.irq_en;                   // [R13]
        // Build-out on at level 0, never at E3
        d.buildout_en = ~eff_lvl & ~eff_e3;                // [R8] [R9]
        d.tx_on       = eff_on;
        // Line gated in the register so the pins come straight from flops
        d.line.pos    = enc_line.pos & eff_on;             // [R17]
        d.line.neg    = enc_line.neg & eff_on;
    end

    // State register
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            q <= '0;
            {q.tx_on_bit, q.mon_self, q.rate_e3, q.buildout_lvl, q.single_rail} <= TLE_CTRL_RST;
        end else begin
            q <= d;
        end
    end

    // Outputs, line released while off
    assign o_prdata          = q.prdata;
    assign o_line_out_pos    = q.line.pos;
    assign o_line_out_neg    = q.line.neg;
    assign o_line_out_oe     = q.tx_on;                    // [R17]
    assign o_buildout_en     = q.buildout_en;
    assign o_drive_fault_out = fault;                      // [R11] [R12]
    assign o_irq             = q.irq;

endmodule

// File: verilog/tle_zs_encoder.sv
// Zero-substitution line encoder, one symbol per transmit clock strobe.
// Assumes i_strobe is a one-cycle pulse at each transmit clock rising edge.
`timescale 1ns/10ps
module tle_zs_encoder
    import tle_pkg::*;
(
    input  wire logic      i_mclk,
    input  wire logic      i_sys_rst,
    input  wire logic      i_strobe,
    input  wire logic      i_single_rail,
    input  wire logic      i_rate_e3,
    input  wire tle_rail_t i_data,
    output tle_rail_t      o_line
);

    tle_enc_state_t q;
    tle_enc_state_t d;
    tle_tag_t       tap;
    logic [2:0]     run;
    logic           pol;

    // Next state of the delay line, run counter and polarity
    always_comb begin
        d   = q;
        tap = i_rate_e3 ? q.pipe[3] : q.pipe[2];
        run = i_rate_e3 ? TLE_HDB3_RUN : TLE_B3ZS_RUN;    // [R1]
        pol = tap.viol ? q.last_pol : ~q.last_pol;
        if (i_strobe) begin
            if (!i_single_rail) begin
                // Rails pass straight, violations kept as pulses
                d.out.pos = i_data.pos;                    // [R6]
                d.out.neg = i_data.neg & ~i_data.pos;      // [R7]
                d.pipe    = '0;
                d.zrun    = 3'h0;
            end else begin
                d.out = '0;
                if (tap.mark) begin
                    d.out.pos  = pol;
                    d.out.neg  = ~pol;
                    d.last_pol = pol;
                    d.parity   = tap.viol ? 1'b0 : ~q.parity;
                end
                d.pipe = {q.pipe[2:0], i_data.pos, 1'b0};
                d.zrun = i_data.pos ? 3'h0 : q.zrun + 3'h1;    // [R19]
                if (!i_data.pos && (q.zrun + 3'h1 == run)) begin
                    // Newest zero becomes V, oldest becomes B if even
                    d.pipe[0] = 2'b11;                     // [R2] [R4]
                    if (!d.parity) begin
                        if (i_rate_e3) d.pipe[3].mark = 1'b1;  // [R5]
                        else d.pipe[2].mark = 1'b1;        // [R3]
                    end
                    d.zrun = 3'h0;
                end
            end
        end
    end

    // State register
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) q <= '0;
        else q <= d;
    end

    assign o_line = q.out;

endmodule
